// ===== shared/tmz_timer0_regs.vh
`ifndef TMZ_TIMER0_REGS_VH
`define TMZ_TIMER0_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define TMZ_OFS_COUNT 4'h0
`define TMZ_OFS_OPTION 4'h4
`define TMZ_OFS_CMPCTL 4'h8
`define TMZ_OFS_CMDSTAT 4'hc

// Option register fields
`define TMZ_OPT_RATIO_MSB 2
`define TMZ_OPT_RATIO_LSB 0
`define TMZ_OPT_ASSIGN_BIT 3
`define TMZ_OPT_EDGE_BIT 4
`define TMZ_OPT_SRC_BIT 5

// Comparator control fields
`define TMZ_CMP_OUT_BIT 7
`define TMZ_CMP_OUTEN_BIT 6
`define TMZ_CMP_CNTSEL_BIT 4

// Command and status fields
`define TMZ_CMD_WDCLR_BIT 0
`define TMZ_STAT_SAMPLE_BIT 0
`define TMZ_STAT_INHIBIT_BIT 1
`define TMZ_STAT_ASSIGN_BIT 2

// Reset values
`define TMZ_RST_COUNT 8'h00
`define TMZ_RST_OPTION 8'hff
`define TMZ_RST_CMPCTL 8'hff
`define TMZ_RST_PRESCALE 8'h00

// Timing
`define TMZ_INHIBIT_CYCLES 2'h2
`define TMZ_PHASE_Q1 2'h0
`define TMZ_PHASE_Q2 2'h1
`define TMZ_PHASE_Q3 2'h2
`define TMZ_PHASE_Q4 2'h3

`endif

// ===== src/tmz_phase_gen.v
`timescale 1ns/1ns
`default_nettype none
`include "tmz_timer0_regs.vh"

// Four-phase instruction cycle: one sys_clk per phase
module tmz_phase_gen (
  input wire sys_clk,
  input wire rst_b,
  output wire [1:0] qPhase,
  output wire q2Strobe,
  output wire q4Strobe
);

  reg [1:0] phase_r;

  // Free-running phase counter, Q1 first after reset
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= `TMZ_PHASE_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Phase strobes are one-cycle enables
  assign qPhase = phase_r;
  assign q2Strobe = (phase_r == `TMZ_PHASE_Q2);
  assign q4Strobe = (phase_r == `TMZ_PHASE_Q4);

endmodule
`default_nettype wire

// ===== src/tmz_prescaler.v
`timescale 1ns/1ns
`default_nettype none
`include "tmz_timer0_regs.vh"

// Eight-stage divider; each stage toggles when all lower stages are one
module tmz_prescaler (
  input wire sys_clk,
  input wire rst_b,
  input wire clear,
  input wire countEn,
  output wire [7:0] scaleCount
);

  localparam [7:0] RST_STAGES = `TMZ_RST_PRESCALE;

  reg [7:0] stage_r;
  wire [8:0] carry;

  // Carry chain standing in for the ripple between stages
  assign carry[0] = countEn;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gStage
      assign carry[i + 1] = carry[i] & stage_r[i];

      // Stage toggle, cleared by reset or a clear action
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          stage_r[i] <= RST_STAGES[i];
        end else if (clear) begin
          stage_r[i] <= 1'b0;
        end else if (carry[i]) begin
          stage_r[i] <= ~stage_r[i];
        end
      end
    end
  endgenerate

  assign scaleCount = stage_r;

endmodule
`default_nettype wire

// ===== src/tmz_timer0.v
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "tmz_timer0_regs.vh"

// Contract
// - Selecting external counting forces the count pin to act as input.
// - Without the divider the count input passes straight to the sampler.
// - Divider output is sampled in phases Q2 and Q4 of each cycle.
// - Assigned divider splits the count input with a symmetrical ripple counter.
// - Timer increments a short synchronisation delay after the external edge.
// - One 8-bit divider serves timer or watchdog, never both together.
// - Assignment bit and three-bit ratio choose divider owner and division.
// - Writing the timer count clears the divider when the timer owns it.
// - Watchdog clear clears divider and watchdog when the watchdog owns it.
// - The divider value is neither readable nor writable by software.
// - Every reset loads the divider with zeros.
// - Assignment may change at any time without halting the timer.
// - Internal source counts instruction cycles; a count write blocks increments until two Q4 strobes pass.
// - Edge select cleared counts rising pin edges, set counts falling edges.
// - Comparator select cleared counts the comparator; its pin enable is ignored.
// - Assigning the divider to the timer gives ratios 1:2 through 1:256.
module tmz_timer0 (
  input wire sys_clk,
  input wire rst_b,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire extCountInput,
  input wire cmpOut,
  input wire watchdogTick,
  output wire extCountInputForceIn,
  output reg watchdogPostTick,
  output reg watchdogClear
);

  // Register state
  reg [7:0] timerCount_r;
  reg [7:0] optionControl_r;
  reg [7:0] cmpControl_r;
  reg ack_r;

  // Count path state
  reg srcPrev_r;
  reg sample_r;
  reg samplePrev_r;
  reg sampleTaken_r;
  reg [1:0] inhibit_r;
  reg wdTapPrev_r;

  wire [1:0] qPhase;
  wire q2Strobe;
  wire q4Strobe;
  wire [7:0] scaleCount;

  wire busReq;
  wire writeTake;
  wire readTake;
  wire countWrite;
  wire cmdWrite;
  wire wdClearCmd;

  wire [2:0] scalerRatio;
  wire scalerAssign;
  wire countEdgeSel;
  wire countSourceSel;
  wire cmpCountSel;
  wire assignTimer;

  wire extLevel;
  wire cmpLevel;
  wire srcLevel;
  wire srcRise;
  wire scalerClear;
  wire scalerEn;
  wire scalerOut;
  wire wdTap;
  wire incReq;

  // Selects one divider stage as an output tap
  function tapBit;
    input [7:0] cnt;
    input [2:0] idx;
    begin
      tapBit = cnt[idx];
    end
  endfunction

  tmz_phase_gen uPhase (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .qPhase(qPhase),
    .q2Strobe(q2Strobe),
    .q4Strobe(q4Strobe)
  );

  tmz_prescaler uScaler (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(scalerClear),
    .countEn(scalerEn),
    .scaleCount(scaleCount)
  );

  // Option and comparator field decode
  assign scalerRatio = optionControl_r[`TMZ_OPT_RATIO_MSB:`TMZ_OPT_RATIO_LSB];
  assign scalerAssign = optionControl_r[`TMZ_OPT_ASSIGN_BIT];
  assign countEdgeSel = optionControl_r[`TMZ_OPT_EDGE_BIT];
  assign countSourceSel = optionControl_r[`TMZ_OPT_SRC_BIT];
  assign cmpCountSel = cmpControl_r[`TMZ_CMP_CNTSEL_BIT];
  assign assignTimer = ~scalerAssign;

  // Pin direction is overridden while external counting is chosen
  assign extCountInputForceIn = countSourceSel;

  // Avalon slave: one wait state, write taken at the second edge, read at the first
  assign busReq = read | write;
  assign waitrequest = busReq & ~ack_r;
  assign writeTake = write & ack_r;
  assign readTake = read & ~ack_r;
  assign countWrite = writeTake & (address == `TMZ_OFS_COUNT);
  assign cmdWrite = writeTake & (address == `TMZ_OFS_CMDSTAT);
  assign wdClearCmd = cmdWrite & writedata[`TMZ_CMD_WDCLR_BIT];

  // Wait-state flag, cleared after each accepted access
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq & ~ack_r;
    end
  end

  // Read data is loaded at the first edge and stands through the second
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (readTake) begin
      case (address)
        `TMZ_OFS_COUNT: begin
          readdata <= {24'h0, timerCount_r};
        end
        `TMZ_OFS_OPTION: begin
          readdata <= {24'h0, optionControl_r};
        end
        `TMZ_OFS_CMPCTL: begin
          readdata <= {24'h0, cmpOut, cmpControl_r[6:0]};
        end
        `TMZ_OFS_CMDSTAT: begin
          // Block state only; divider contents never appear here
          readdata <= {29'h0, assignTimer, (inhibit_r != 2'h0), sample_r};
        end
        default: begin
          readdata <= 32'h0;
        end
      endcase
    end
  end

  // Option and comparator control; assignment may change at any time
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      optionControl_r <= `TMZ_RST_OPTION;
      cmpControl_r <= `TMZ_RST_CMPCTL;
    end else if (writeTake) begin
      if (address == `TMZ_OFS_OPTION) begin
        optionControl_r <= writedata[7:0];
      end
      if (address == `TMZ_OFS_CMPCTL) begin
        cmpControl_r <= writedata[7:0];
      end
    end
  end

  // Count source: edge select inverts the level so a rise is always counted
  assign extLevel = extCountInput ^ countEdgeSel;
  assign cmpLevel = cmpOut ^ countEdgeSel;
  // Internal source rises once per instruction cycle, at Q3
  assign srcLevel = ~countSourceSel ? qPhase[1] :
                    (cmpCountSel ? extLevel : cmpLevel);

  // Previous source level for edge detection
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      srcPrev_r <= 1'b0;
    end else begin
      srcPrev_r <= srcLevel;
    end
  end

  assign srcRise = srcLevel & ~srcPrev_r;

  // Divider owner: timer source edges or watchdog ticks, never both
  assign scalerEn = assignTimer ? srcRise : watchdogTick;
  // Clearing: count write when timer owns it, watchdog clear otherwise
  assign scalerClear = (countWrite & assignTimer) |
                       (wdClearCmd & ~assignTimer);

  // Timer sees the divider tap or the raw source level
  assign scalerOut = assignTimer ? tapBit(scaleCount, scalerRatio) : srcLevel;

  // Sampling of the divider output in Q2 and Q4
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_r <= 1'b0;
      samplePrev_r <= 1'b0;
      sampleTaken_r <= 1'b0;
    end else begin
      sampleTaken_r <= q2Strobe | q4Strobe;
      if (q2Strobe | q4Strobe) begin
        sample_r <= scalerOut;
        samplePrev_r <= sample_r;
      end
    end
  end

  // Increment only after a sampled rise, hence a delay after the pin edge
  assign incReq = sampleTaken_r & sample_r & ~samplePrev_r;

  // Timer count: a write wins and blocks increments until two Q4 strobes have passed
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timerCount_r <= `TMZ_RST_COUNT;
      inhibit_r <= 2'h0;
    end else if (countWrite) begin
      timerCount_r <= writedata[7:0];
      inhibit_r <= `TMZ_INHIBIT_CYCLES;
    end else begin
      if (incReq && (inhibit_r == 2'h0)) begin
        timerCount_r <= timerCount_r + 8'h01;
      end
      if (q4Strobe && (inhibit_r != 2'h0)) begin
        inhibit_r <= inhibit_r - 2'h1;
      end
    end
  end

  // Watchdog tap: ratio zero passes ticks, otherwise stage ratio-1
  assign wdTap = tapBit(scaleCount, scalerRatio - 3'h1);

  // Previous watchdog tap for edge detection
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdTapPrev_r <= 1'b0;
    end else begin
      wdTapPrev_r <= wdTap;
    end
  end

  // Watchdog postscaled tick and clear pulses
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdogPostTick <= 1'b0;
      watchdogClear <= 1'b0;
    end else begin
      watchdogClear <= wdClearCmd;
      if (assignTimer) begin
        // Without the divider the watchdog ticks pass unscaled
        watchdogPostTick <= watchdogTick;
      end else if (scalerRatio == 3'h0) begin
        watchdogPostTick <= watchdogTick;
      end else begin
        watchdogPostTick <= wdTap & ~wdTapPrev_r;
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/tmz_pin_src.sv
`timescale 1ns/1ns
`default_nettype none
// Count pin source: num pulses, each level held half cycles
module tmz_pin_src (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] num,
  input wire logic [3:0] half,
  output logic pin
);
  // Pin idles low between trains
  initial pin = 1'b0;
  always @(posedge go) begin
    repeat (num) begin
      repeat (half) @(posedge sys_clk);
      pin <= 1'b1;
      repeat (half) @(posedge sys_clk);
      pin <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tmz_timer0_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmz_timer0_regs.vh"
module tmz_timer0_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic extCountInput,
  input wire logic cmpOut,
  input wire logic watchdogTick,
  input wire logic extCountInputForceIn,
  input wire logic watchdogPostTick,
  input wire logic watchdogClear
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] optShadow_r;
  // Accepted writes to option and command
  wire optWr = write && !waitrequest && address == `TMZ_OFS_OPTION;
  wire clrWr = write && !waitrequest && address == `TMZ_OFS_CMDSTAT && writedata[0];
  // Shadow option register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      optShadow_r <= `TMZ_RST_OPTION;
    end else if (optWr) begin
      optShadow_r <= writedata[7:0];
    end
  end
  sequence sClrSoon;
    ##[1:2] watchdogClear;
  endsequence
  sequence sPostSoon;
    ##[1:2] watchdogPostTick;
  endsequence
  a_force_in_src: assert property (extCountInputForceIn == optShadow_r[5])
    else $error("pin direction override wrong");
  a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0 |->
    readdata == 32'h0) else $error("unmapped read not zero");
  a_wdclr_follows: assert property (clrWr |-> sClrSoon)
    else $error("watchdog clear missing");
  a_wdclr_cause: assert property (watchdogClear |-> $past(clrWr) || $past(clrWr, 2))
    else $error("stray watchdog clear");
  a_post_timer_pass: assert property (!optShadow_r[3] && watchdogTick |->
    ##1 watchdogPostTick) else $error("watchdog tick not passed while timer owns divider");
  a_post_unscaled: assert property (optShadow_r[3] && optShadow_r[2:0] == 3'h0 &&
    watchdogTick |-> sPostSoon) else $error("unscaled watchdog tick lost");
  a_post_cause: assert property (watchdogPostTick |->
    $past(watchdogTick) || $past(watchdogTick, 2)) else $error("post tick without tick");
  a_reset_state: assert property ($rose(rst_b) |-> extCountInputForceIn &&
    !watchdogPostTick && !watchdogClear) else $error("outputs wrong after reset");
endmodule
bind tmz_timer0 tmz_timer0_chk tmz_timer0_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .extCountInput(extCountInput),
  .cmpOut(cmpOut), .watchdogTick(watchdogTick), .extCountInputForceIn(extCountInputForceIn),
  .watchdogPostTick(watchdogPostTick), .watchdogClear(watchdogClear));
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmz_timer0_regs.vh"
module tb;
  localparam logic [3:0] CNT = `TMZ_OFS_COUNT;
  localparam logic [3:0] OPT = `TMZ_OFS_OPTION;
  localparam logic [3:0] CMP = `TMZ_OFS_CMPCTL;
  localparam logic [3:0] CMD = `TMZ_OFS_CMDSTAT;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic cmpOut = 1'b0;
  logic watchdogTick = 1'b0;
  logic go = 1'b0;
  logic [7:0] num = 8'h0;
  logic [3:0] half = 4'h2;
  logic [31:0] rdv, a;
  wire [31:0] readdata;
  wire waitrequest, extCountInput, extCountInputForceIn, watchdogPostTick, watchdogClear;
  integer numErrors = 0, checkCount = 0, cycles = 0, posts = 0, i;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  tmz_timer0 tmz_timer0_inst (.sys_clk(sys_clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .extCountInput(extCountInput), .cmpOut(cmpOut),
    .watchdogTick(watchdogTick), .extCountInputForceIn(extCountInputForceIn),
    .watchdogPostTick(watchdogPostTick), .watchdogClear(watchdogClear));
  tmz_pin_src tmz_pin_src_inst (.sys_clk(sys_clk), .go(go), .num(num), .half(half),
    .pin(extCountInput));
  // Count post ticks and cut a hang short
  always @(posedge sys_clk) begin
    if (watchdogPostTick === 1'b1) posts <= posts + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      numErrors = numErrors + 1;
      endSim;
    end
  end
  task endSim;
    begin
      $display("checks %0d errors %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checkCount = checkCount + 1;
      if (got !== exp) begin
        numErrors = numErrors + 1;
        $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One bus access, held until waitrequest is sampled low at a rising edge
  task xfer(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    begin
      @(posedge sys_clk);
      read <= !w;
      write <= w;
      address <= ad;
      writedata <= wd;
      @(posedge sys_clk);
      while (waitrequest !== 1'b0) @(posedge sys_clk);
      rdv = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd);
  endtask
  task rdc(input logic [3:0] ad, input logic [31:0] e);
    begin
      xfer(1'b0, ad, 32'h0);
      chk(rdv, e);
    end
  endtask
  // Count growth between two reads w+3 cycles apart
  task span(input integer w, input logic [31:0] e);
    begin
      repeat (13) @(posedge sys_clk);
      xfer(1'b0, CNT, 32'h0);
      a = rdv;
      repeat (w) @(posedge sys_clk);
      xfer(1'b0, CNT, 32'h0);
      chk((rdv - a) & 32'hff, e);
    end
  endtask
  task ticks(input integer n);
    begin
      repeat (n) begin
        @(posedge sys_clk);
        watchdogTick <= 1'b1;
        @(posedge sys_clk);
        watchdogTick <= 1'b0;
      end
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task pulses(input logic [7:0] n, input logic [3:0] h);
    begin
      repeat (12) @(posedge sys_clk);
      num <= n;
      half <= h;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (n * h * 2 + 10) @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(OPT, 32'hff);
    rdc(4'h2, 32'h0);
    ticks(63);
    chk(posts, 0);
    ticks(1);
    chk(posts, 1);
    ticks(100);
    wr(CMD, 32'h1);
    ticks(63);
    chk(posts, 1);
    wr(OPT, 32'h08);
    ticks(2);
    chk(posts, 3);
    $display("watchdog test done");
    wr(CNT, 32'h10);
    rdc(CNT, 32'h10);
    span(37, 32'ha);
    wr(CMD, 32'h1);
    for (i = 0; i < 8; i = i + 1) begin
      wr(OPT, i);
      wr(CNT, 32'h0);
      span(1021, 32'h80 >> i);
    end
    repeat (1400) @(posedge sys_clk);
    wr(CNT, 32'h0);
    repeat (400) @(posedge sys_clk);
    rdc(CNT, 32'h0);
    $display("timer test done");
    wr(CMD, 32'h1);
    wr(CNT, 32'h0);
    wr(OPT, 32'h08);
    wr(CMD, 32'h1);
    wr(CMP, 32'h10);
    for (i = 0; i < 2; i = i + 1) begin
      wr(OPT, 32'h28 | (i << 4));
      wr(CNT, 32'h0);
      pulses(8'h9, 4'h2);
      rdc(CNT, 32'h9);
    end
    chk({31'h0, extCountInputForceIn}, 32'h1);
    wr(CMD, 32'h1);
    wr(OPT, 32'h20);
    xfer(1'b0, CMD, 32'h0);
    chk(rdv & 32'h4, 32'h4);
    ticks(2);
    chk(posts, 5);
    wr(CNT, 32'h0);
    pulses(8'h14, 4'h1);
    rdc(CNT, 32'ha);
    $display("pin test done");
    wr(CMP, 32'h40);
    wr(CNT, 32'h0);
    repeat (12) @(posedge sys_clk);
    repeat (6) begin
      cmpOut <= 1'b1;
      repeat (4) @(posedge sys_clk);
      cmpOut <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    rdc(CNT, 32'h3);
    $display("comparator test done");
    endSim;
  end
endmodule
`default_nettype wire
